// ### pkg/gpib_remote_defs.vh
// Purpose: constants of the remote-control state logic
// Assumes: included by its bare name
// Notes:   offsets are word indices on the register bus; the byte address is four times the offset
`ifndef GPIB_REMOTE_DEFS_VH
`define GPIB_REMOTE_DEFS_VH
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_ERROR       4'h2
`define REG_BUS_ADDR    4'h3
`define REG_PLOT_ADDR   4'h4
`define REG_DELAY       4'h5
`define CTRL_SRQ_EN     0
`define ADDR_MAX        5'h1e
`define ADDR_DEFAULT    5'h04
`define DELAY_MAX       27'h5f5e0ff
`define ERR_NONE        8'h00
`define ERR_AUTOSCALE   8'h3c
`define ERR_NOT_REMOTE  8'h0b
`define ERR_BAD_DELAY   8'h0c
`define MODE_UPDT       3'h0
`define MODE_UPDC       3'h1
`define MODE_PLOT       3'h2
`define MODE_TEMP       3'h3
`define MODE_STATUS     3'h4
`define MODE_SAPLOT     3'h5
`define CMD_MEAS        4'h0
`define CMD_AUTO_MEAS   4'h1
`define CMD_AUTO_MARK   4'h2
`define CMD_MARK        4'h3
`define CMD_DELAY       4'h4
`define CMD_MODE        4'h5
`define KEY_NONE        2'h0
`define KEY_MENU        2'h1
`define KEY_F1          2'h2
`define KEY_F2          2'h3
`endif

// ### core/gpib_remote_output_control.v
// Purpose: remote/local, lockout, command sequencing and output mode state
// Assumes: bus handshake and parsing done elsewhere on sys_clk_i
// Notes:   pin levels ren, addressed states and keys pass two flip-flops
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`include "gpib_remote_defs.vh"

module gpib_remote_output_control #(
    parameter DELAY_W = 27
) (
    input  wire                sys_clk_i,
    input  wire                rstn_i,
    // register bus
    input  wire [5:0]          avs_address_i,
    input  wire                avs_read_i,
    input  wire                avs_write_i,
    input  wire [31:0]         avs_writedata_i,
    output reg  [31:0]         avs_readdata_o,
    output wire                avs_waitrequest_o,
    // non-volatile storage
    input  wire [4:0]          nv_bus_addr_i,
    input  wire [4:0]          nv_plot_addr_i,
    output reg                 nv_wr_o,
    output reg  [4:0]          nv_bus_addr_o,
    output reg  [4:0]          nv_plot_addr_o,
    // pin levels
    input  wire                ren_i,
    input  wire                lads_i,
    input  wire                tacs_i,
    input  wire [1:0]          key_i,
    // parsed bus events, same clock
    input  wire                get_i,
    input  wire                data_rx_i,
    input  wire                gtl_i,
    input  wire                llo_i,
    input  wire                cmd_valid_i,
    input  wire [3:0]          cmd_code_i,
    input  wire [DELAY_W-1:0]  cmd_arg_i,
    output wire                cmd_ready_o,
    // measurement engine
    output reg                 autoscale_start_o,
    input  wire                autoscale_done_i,
    input  wire                autoscale_fail_i,
    output reg                 marker_start_o,
    input  wire                marker_done_i,
    input  wire                marker_fail_i,
    output reg                 meas_start_o,
    input  wire                meas_ready_i,
    output wire                abort_o,
    // output formatter
    output wire                out_req_o,
    input  wire                out_done_i,
    output reg  [2:0]          out_mode_o,
    output reg                 untalk_self_o,
    output reg  [DELAY_W-1:0]  delay_o,
    output reg                 srq_o,
    output reg                 remote_o,
    output reg                 llo_lamp_o,
    output reg                 suspend_o,
    output reg                 emulation_o
);

    localparam S_IDLE = 3'h0;
    localparam S_PARSE = 3'h1;
    localparam S_AUTO = 3'h2;
    localparam S_MARK = 3'h3;
    localparam S_MEAS = 3'h4;
    localparam S_READY = 3'h5;

    function valid_addr;
        input [31:0] v;
        begin
            valid_addr = (v <= {27'h0, `ADDR_MAX});
        end
    endfunction

    // synchronisers
    reg        ren_m, ren_s;
    reg        lads_m, lads_s, lads_d;
    reg        tacs_m, tacs_s, tacs_d;
    reg [1:0]  key_m, key_s, key_d;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {ren_m, ren_s, lads_m, lads_s, lads_d, tacs_m, tacs_s, tacs_d} <= 8'h00;
            {key_m, key_s, key_d} <= {3{`KEY_NONE}};
        end else begin
            ren_m  <= ren_i;
            ren_s  <= ren_m;
            lads_m <= lads_i;
            lads_s <= lads_m;
            lads_d <= lads_s;
            tacs_m <= tacs_i;
            tacs_s <= tacs_m;
            tacs_d <= tacs_s;
            key_m  <= key_i;
            key_s  <= key_m;
            key_d  <= key_s;
        end
    end

    wire       lads_rise = lads_s & ~lads_d;
    wire       addr_chg = (lads_s ^ lads_d) | (tacs_s ^ tacs_d);
    wire [1:0] key_hit = (key_d == `KEY_NONE) ? key_s : `KEY_NONE;
    wire       talker = remote_o & tacs_s & ~suspend_o;
    wire       tacs_rise = talker & ~tacs_d;
    wire       untalk = tacs_d & ~tacs_s;

    reg        srq_en, llo;
    reg [7:0]  err_code;
    reg [4:0]  bus_addr, plot_addr;
    reg [2:0]  state;
    reg        want_auto, want_mark;
    reg        was_talker, out_finished;
    reg        data_ready, last_updc;
    reg        loaded, ack;

    assign cmd_ready_o = remote_o & ~suspend_o;
    wire   cmd_take = cmd_valid_i & cmd_ready_o;
    wire   new_run = cmd_take & (cmd_code_i <= `CMD_MARK);
    assign abort_o = new_run | (untalk & was_talker);
    wire   self_term = (out_mode_o != `MODE_UPDT) & (out_mode_o != `MODE_UPDC);
    assign out_req_o = talker & ~out_finished & (self_term | data_ready);

    // remote, lockout, escape
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            remote_o    <= 1'b0;
            llo         <= 1'b0;
            llo_lamp_o  <= 1'b0;
            suspend_o   <= 1'b0;
            emulation_o <= 1'b0;
        end else begin
            if (!ren_s) begin
                remote_o   <= 1'b0;
                llo        <= 1'b0;
                llo_lamp_o <= 1'b0;
                suspend_o  <= 1'b0;
            end else if (gtl_i) begin
                remote_o  <= 1'b0;
                suspend_o <= 1'b0;
            end else if (lads_rise && !remote_o) begin
                remote_o <= 1'b1;
            end else if (suspend_o) begin
                if (key_hit == `KEY_F1) begin
                    remote_o  <= 1'b0;
                    suspend_o <= 1'b0;
                end else if (key_hit == `KEY_F2) begin
                    suspend_o <= 1'b0;
                end
            end else if (remote_o && !llo && key_hit == `KEY_MENU) begin
                suspend_o <= 1'b1;
            end
            if (ren_s && llo_i && remote_o) begin
                llo <= 1'b1;
            end
            if (llo && (addr_chg || key_hit != `KEY_NONE)) begin
                llo_lamp_o <= 1'b1;
            end
        end
    end

    // command sequencing
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state             <= S_IDLE;
            want_auto         <= 1'b0;
            want_mark         <= 1'b0;
            autoscale_start_o <= 1'b0;
            marker_start_o    <= 1'b0;
            meas_start_o      <= 1'b0;
            data_ready        <= 1'b0;
        end else begin
            autoscale_start_o <= 1'b0;
            marker_start_o    <= 1'b0;
            meas_start_o      <= 1'b0;
            if (abort_o) begin
                state      <= new_run ? S_PARSE : S_IDLE;
                want_auto  <= new_run & ((cmd_code_i == `CMD_AUTO_MEAS) |
                                         (cmd_code_i == `CMD_AUTO_MARK));
                want_mark  <= new_run & ((cmd_code_i == `CMD_AUTO_MARK) |
                                         (cmd_code_i == `CMD_MARK));
                data_ready <= 1'b0;
            end else if (!suspend_o) begin
                case (state)
                    S_PARSE: begin
                        if (want_auto) begin
                            autoscale_start_o <= 1'b1;
                            state <= S_AUTO;
                        end else if (want_mark) begin
                            marker_start_o <= 1'b1;
                            state <= S_MARK;
                        end else begin
                            meas_start_o <= 1'b1;
                            state <= S_MEAS;
                        end
                    end
                    S_AUTO: begin
                        if (autoscale_fail_i) begin
                            state <= S_IDLE;
                        end else if (autoscale_done_i) begin
                            want_auto <= 1'b0;
                            state <= S_PARSE;
                        end
                    end
                    S_MARK: begin
                        if (marker_fail_i) begin
                            state <= S_IDLE;
                        end else if (marker_done_i) begin
                            want_mark <= 1'b0;
                            meas_start_o <= 1'b1;
                            state <= S_MEAS;
                        end
                    end
                    S_MEAS: begin
                        if (meas_ready_i) begin
                            data_ready <= 1'b1;
                            state <= S_READY;
                        end
                    end
                    S_READY: begin
                        if (out_done_i && talker) begin
                            data_ready <= 1'b0;
                            state <= S_IDLE;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // service request; an event in the clearing cycle wins
    wire srq_set = srq_en & (
        (state == S_AUTO & (autoscale_fail_i | autoscale_done_i)) |
        (state == S_MARK & (marker_fail_i | marker_done_i)) |
        (state == S_MEAS & meas_ready_i & ~talker) |
        ((get_i | data_rx_i) & lads_s & ~remote_o));

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            srq_o <= 1'b0;
        end else if (srq_set && !suspend_o) begin
            srq_o <= 1'b1;
        end else if (tacs_rise) begin
            srq_o <= 1'b0;
        end
    end

    // output mode
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_mode_o    <= `MODE_UPDT;
            last_updc     <= 1'b0;
            out_finished  <= 1'b0;
            was_talker    <= 1'b0;
            untalk_self_o <= 1'b0;
        end else begin
            untalk_self_o <= 1'b0;
            if (tacs_rise) begin
                was_talker <= 1'b1;
            end
            if (cmd_take && cmd_code_i == `CMD_MODE && cmd_arg_i[2:0] <= `MODE_SAPLOT) begin
                out_mode_o   <= cmd_arg_i[2:0];
                out_finished <= 1'b0;
                if (cmd_arg_i[2:0] == `MODE_UPDT) begin
                    last_updc <= 1'b0;
                end else if (cmd_arg_i[2:0] == `MODE_UPDC) begin
                    last_updc <= 1'b1;
                end
            end else if (untalk) begin
                was_talker   <= 1'b0;
                out_finished <= 1'b0;
                if (self_term) begin
                    out_mode_o <= last_updc ? `MODE_UPDC : `MODE_UPDT;
                end
            end else if (out_done_i && talker && self_term) begin
                out_finished  <= 1'b1;
                untalk_self_o <= (out_mode_o == `MODE_SAPLOT);
            end
        end
    end

    // register bus: one wait cycle, then answer
    wire [3:0] reg_idx = avs_address_i[5:2];
    wire       req = avs_read_i | avs_write_i;
    wire       wr = avs_write_i & ack;
    assign avs_waitrequest_o = req & ~ack;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack            <= 1'b0;
            avs_readdata_o <= 32'h0;
        end else begin
            ack <= req & ~ack;
            if (avs_read_i && !ack) begin
                case (reg_idx)
                    `REG_CTRL:      avs_readdata_o <= {31'h0, srq_en};
                    `REG_STATUS:    avs_readdata_o <= {16'h0, 1'b0, state, 1'b0,
                                        out_mode_o, srq_o, data_ready, emulation_o,
                                        suspend_o, llo_lamp_o, llo, remote_o,
                                        out_finished};
                    `REG_ERROR:     avs_readdata_o <= {24'h0, err_code};
                    `REG_BUS_ADDR:  avs_readdata_o <= {27'h0, bus_addr};
                    `REG_PLOT_ADDR: avs_readdata_o <= {27'h0, plot_addr};
                    `REG_DELAY:     avs_readdata_o <= {{(32-DELAY_W){1'b0}}, delay_o};
                    default:        avs_readdata_o <= 32'h0;
                endcase
            end
        end
    end

    // configuration, addresses and error code
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            srq_en         <= 1'b0;
            bus_addr       <= `ADDR_DEFAULT;
            plot_addr      <= `ADDR_DEFAULT;
            loaded         <= 1'b0;
            nv_wr_o        <= 1'b0;
            nv_bus_addr_o  <= `ADDR_DEFAULT;
            nv_plot_addr_o <= `ADDR_DEFAULT;
            delay_o        <= {DELAY_W{1'b0}};
            err_code       <= `ERR_NONE;
        end else begin
            nv_wr_o <= 1'b0;
            loaded  <= 1'b1;
            if (!loaded) begin
                // stored address, default 4 when storage holds junk
                bus_addr  <= valid_addr({27'h0, nv_bus_addr_i}) ? nv_bus_addr_i
                                                                 : `ADDR_DEFAULT;
                plot_addr <= valid_addr({27'h0, nv_plot_addr_i}) ? nv_plot_addr_i
                                                                  : `ADDR_DEFAULT;
            end else if (wr && reg_idx == `REG_BUS_ADDR && valid_addr(avs_writedata_i)) begin
                bus_addr       <= avs_writedata_i[4:0];
                nv_bus_addr_o  <= avs_writedata_i[4:0];
                nv_plot_addr_o <= plot_addr;
                nv_wr_o        <= 1'b1;
            end else if (wr && reg_idx == `REG_PLOT_ADDR && valid_addr(avs_writedata_i)) begin
                plot_addr      <= avs_writedata_i[4:0];
                nv_plot_addr_o <= avs_writedata_i[4:0];
                nv_bus_addr_o  <= bus_addr;
                nv_wr_o        <= 1'b1;
            end
            if (wr && reg_idx == `REG_CTRL) begin
                srq_en <= avs_writedata_i[`CTRL_SRQ_EN];
            end
            if (cmd_take && cmd_code_i == `CMD_DELAY
                    && cmd_arg_i <= `DELAY_MAX) begin
                delay_o <= cmd_arg_i;
            end
            if (state == S_AUTO && autoscale_fail_i && !abort_o && !suspend_o) begin
                err_code <= `ERR_AUTOSCALE;
            end else if ((get_i || data_rx_i) && lads_s && !remote_o) begin
                err_code <= `ERR_NOT_REMOTE;
            end else if (cmd_take && cmd_code_i == `CMD_DELAY
                    && cmd_arg_i > `DELAY_MAX) begin
                err_code <= `ERR_BAD_DELAY;
            end else if (wr && reg_idx == `REG_ERROR) begin
                err_code <= `ERR_NONE;
            end
        end
    end

endmodule // gpib_remote_output_control

// ### testbench/gpib_remote_output_control_monitor.sv
// Purpose: concurrent checks on the remote-control block ports
// Assumes: bound into every instance of the block
// Notes:   pin inputs pass two flip-flops before use
`include "gpib_remote_defs.vh"
module gpib_remote_output_control_monitor #(
    parameter DELAY_W = 27
) (
    input wire       sys_clk_i,
    input wire       rstn_i,
    input wire       avs_read_i,
    input wire       avs_write_i,
    input wire       avs_waitrequest_o,
    input wire       ren_i,
    input wire       gtl_i,
    input wire       cmd_valid_i,
    input wire [3:0] cmd_code_i,
    input wire       cmd_ready_o,
    input wire       autoscale_start_o,
    input wire       meas_start_o,
    input wire       abort_o,
    input wire       out_req_o,
    input wire       out_done_i,
    input wire [2:0] out_mode_o,
    input wire       untalk_self_o,
    input wire       srq_o,
    input wire       remote_o,
    input wire       llo_lamp_o,
    input wire       suspend_o,
    input wire       emulation_o,
    input wire [4:0] nv_bus_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence taken_s(c);
        cmd_valid_i && cmd_ready_o && cmd_code_i == c;
    endsequence
    sequence self_done_s;
        out_done_i && out_mode_o >= `MODE_PLOT;
    endsequence
    bus_wait_a: assert property ($rose(avs_read_i || avs_write_i) |->
        avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus wait state wrong");
    auto_start_a: assert property (taken_s(`CMD_AUTO_MEAS) |-> ##2 autoscale_start_o)
        else $error("autoscale start late");
    run_abort_a: assert property (cmd_valid_i && cmd_ready_o && cmd_code_i <= `CMD_MARK
        |-> abort_o) else $error("run not aborted");
    local_quiet_a: assert property (!remote_o |-> !cmd_ready_o && !out_req_o)
        else $error("activity while local");
    suspend_freeze_a: assert property (suspend_o |-> !cmd_ready_o && !meas_start_o
        && !autoscale_start_o) else $error("activity in escape");
    ren_drop_a: assert property (!ren_i [*4] |-> !remote_o)
        else $error("remote held with ren low");
    gtl_local_a: assert property (gtl_i |=> !remote_o)
        else $error("go to local ignored");
    self_stop_a: assert property (self_done_s |=> !out_req_o)
        else $error("output after self stop");
    plot_untalk_a: assert property (self_done_s and out_mode_o == `MODE_SAPLOT
        |=> untalk_self_o) else $error("no self untalk");
    mode_range_a: assert property (out_mode_o <= `MODE_SAPLOT)
        else $error("output mode out of range");
    native_mode_a: assert property (!emulation_o)
        else $error("emulation mode active");
    addr_range_a: assert property (nv_bus_addr_o <= `ADDR_MAX)
        else $error("bus address above 30");
    reset_state_a: assert property ($rose(rstn_i) |-> !remote_o && !srq_o && !llo_lamp_o
        && out_mode_o == `MODE_UPDT) else $error("power-up state wrong");
endmodule // gpib_remote_output_control_monitor
bind gpib_remote_output_control gpib_remote_output_control_monitor #(.DELAY_W(DELAY_W))
    gpib_remote_output_control_monitor_i (.sys_clk_i, .rstn_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .ren_i, .gtl_i, .cmd_valid_i, .cmd_code_i, .cmd_ready_o,
    .autoscale_start_o, .meas_start_o, .abort_o, .out_req_o, .out_done_i, .out_mode_o,
    .untalk_self_o, .srq_o, .remote_o, .llo_lamp_o, .suspend_o, .emulation_o, .nv_bus_addr_o);

// ### testbench/engine_model.sv
// Purpose: measurement engine and output formatter stand-in
// Assumes: driven by the block
// Notes:   latencies of 2 to 5 cycles; abort drops pending work
module engine_model (
    input  wire  clk_i,
    input  wire  rstn_i,
    input  wire  as_go_i,
    input  wire  mk_go_i,
    input  wire  ms_go_i,
    input  wire  abort_i,
    input  wire  as_bad_i,
    input  wire  out_req_i,
    output logic as_done_o,
    output logic as_fail_o,
    output logic mk_done_o,
    output logic ms_rdy_o,
    output logic out_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int c_as, c_mk, c_ms, c_out;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {c_as, c_mk, c_ms, c_out} <= '0;
            {as_done_o, as_fail_o, mk_done_o, ms_rdy_o, out_done_o} <= '0;
        end else begin
            c_as <= as_go_i ? 2 + $urandom % 4 : (abort_i || c_as == 0) ? 0 : c_as - 1;
            c_mk <= mk_go_i ? 2 + $urandom % 4 : (abort_i || c_mk == 0) ? 0 : c_mk - 1;
            c_ms <= ms_go_i ? 2 + $urandom % 4 : (abort_i || c_ms == 0) ? 0 : c_ms - 1;
            c_out <= (!out_req_i || c_out == 3) ? 0 : c_out + 1;
            as_done_o <= c_as == 1 && !abort_i && !as_bad_i;
            as_fail_o <= c_as == 1 && !abort_i && as_bad_i;
            mk_done_o <= c_mk == 1 && !abort_i;
            ms_rdy_o <= c_ms == 1 && !abort_i;
            out_done_o <= out_req_i && c_out == 2;
        end
    end
endmodule // engine_model

// ### testbench/tb.sv
// Purpose: self-checking bench of the remote-control block
// Assumes: engine_model answers starts and output requests
// Notes:   outputs looked at on the falling edge, nv_plot_addr_o and delay_o just after a rising edge
`include "gpib_remote_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 0, rstn_i = 0, avs_read_i = 0, avs_write_i = 0, as_bad = 0;
    logic        ren_i = 0, lads_i = 0, tacs_i = 0, data_rx_i = 0, gtl_i = 0, llo_i = 0;
    logic        cmd_valid_i = 0, get_i = 0;
    logic [5:0]  avs_address_i = '0;
    logic [31:0] avs_writedata_i = '0, exp_q[$], msk_q[$];
    logic [4:0]  nv_bus_addr_i = '0, nv_plot_addr_i = 5'h1f;
    logic [1:0]  key_i = '0;
    logic [3:0]  cmd_code_i = '0;
    logic [26:0] cmd_arg_i = '0;
    wire  [31:0] avs_readdata_o;
    wire  [26:0] delay_o;
    wire  [4:0]  nv_bus_addr_o, nv_plot_addr_o;
    wire  [2:0]  out_mode_o;
    wire         avs_waitrequest_o, nv_wr_o, cmd_ready_o, autoscale_start_o, marker_start_o;
    wire         meas_start_o, abort_o, out_req_o, untalk_self_o, srq_o, remote_o, llo_lamp_o;
    wire         suspend_o, emulation_o, as_done, as_fail, mk_done, ms_rdy, out_done;
    int          n_fail = 0, compares = 0;
    string       nm[11] = '{"remote_o", "autoscale_start_o", "marker_start_o", "meas_start_o",
        "srq_o", "suspend_o", "untalk_self_o", "out_req_o", "abort_o", "llo_lamp_o", "cmd_ready_o"};
    gpib_remote_output_control #(.DELAY_W(27)) gpib_remote_output_control_i (
        .sys_clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_readdata_o, .avs_waitrequest_o, .nv_bus_addr_i, .nv_plot_addr_i, .nv_wr_o,
        .nv_bus_addr_o, .nv_plot_addr_o, .ren_i, .lads_i, .tacs_i, .key_i, .get_i,
        .data_rx_i, .gtl_i, .llo_i, .cmd_valid_i, .cmd_code_i, .cmd_arg_i, .cmd_ready_o,
        .autoscale_start_o, .autoscale_done_i(as_done), .autoscale_fail_i(as_fail),
        .marker_start_o, .marker_done_i(mk_done), .marker_fail_i(1'b0), .meas_start_o,
        .meas_ready_i(ms_rdy), .abort_o, .out_req_o, .out_done_i(out_done), .out_mode_o,
        .untalk_self_o, .delay_o, .srq_o, .remote_o, .llo_lamp_o, .suspend_o, .emulation_o);
    engine_model engine_model_i (.clk_i(sys_clk_i), .rstn_i, .as_go_i(autoscale_start_o),
        .mk_go_i(marker_start_o), .ms_go_i(meas_start_o), .abort_i(abort_o), .as_bad_i(as_bad),
        .out_req_i(out_req_o), .as_done_o(as_done), .as_fail_o(as_fail), .mk_done_o(mk_done),
        .ms_rdy_o(ms_rdy), .out_done_o(out_done));
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        compares++;
        if (got !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask
    function automatic logic sig(input int k);
        logic [10:0] v;
        v = {cmd_ready_o, llo_lamp_o, abort_o, out_req_o, untalk_self_o, suspend_o, srq_o,
             meas_start_o, marker_start_o, autoscale_start_o, remote_o};
        return v[k];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // lim 1 is a plain look; longer limits end the run when used up
    task automatic await(input int k, input logic v, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(negedge sys_clk_i);
            if (sig(k) === v) break;
        end
        chk(nm[k], 32'(v), (n == lim) ? 32'(~v) : 32'(v));
        @(posedge sys_clk_i);
        if (n == lim && lim > 1) tally_and_finish();
    endtask
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
        int n;
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        for (n = 0; n < 20; n++) begin
            @(negedge sys_clk_i);
            if (avs_waitrequest_o === 1'b0) break;
            @(posedge sys_clk_i);
        end
        @(posedge sys_clk_i);
        avs_write_i <= 0;
        avs_read_i <= 0;
        tick(1);
        if (n == 20) chk("avs_waitrequest_o", 0, 1);
        if (n == 20) tally_and_finish();
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(0, idx, '0);
    endtask
    always @(negedge sys_clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
            chk("avs_readdata_o", exp_q.pop_front(), avs_readdata_o & msk_q.pop_front());
    end
    task automatic cmd(input logic [3:0] c, input logic [26:0] a);
        cmd_code_i <= c;
        cmd_arg_i <= a;
        cmd_valid_i <= 1;
        tick(1);
        cmd_valid_i <= 0;
        tick(1);
    endtask
    task automatic key(input logic [1:0] k);
        key_i <= k;
        tick(4);
        key_i <= `KEY_NONE;
        tick(4);
    endtask
    initial begin
        int r;
        nv_bus_addr_i = 5'($urandom(39) % 31);
        tick(3);
        rstn_i <= 1;
        tick(2);
        rd(`REG_STATUS, 0, 32'h7fe);
        rd(`REG_BUS_ADDR, 32'(nv_bus_addr_i), 32'h1f);
        rd(`REG_PLOT_ADDR, 32'(`ADDR_DEFAULT), 32'h1f);
        bus(1, `REG_BUS_ADDR, 32'h1f);
        bus(1, `REG_PLOT_ADDR, 32'h1e);
        rd(`REG_BUS_ADDR, 32'(nv_bus_addr_i), 32'h1f);
        rd(`REG_PLOT_ADDR, 32'h1e, 32'h1f);
        chk("nv_plot_addr_o", 32'h1e, 32'(nv_plot_addr_o));
        rd(4'h7, 0, '1);
        lads_i <= 1;
        tacs_i <= 1;
        tick(4);
        {get_i, data_rx_i} <= 2'($urandom_range(2, 1));
        tick(1);
        {get_i, data_rx_i} <= 2'h0;
        await(7, 0, 1);
        rd(`REG_ERROR, 32'(`ERR_NOT_REMOTE), 32'hff);
        bus(1, `REG_ERROR, 0);
        {lads_i, tacs_i, ren_i} <= 3'b001;
        tick(4);
        lads_i <= 1;
        await(0, 1, 20);
        bus(1, `REG_CTRL, 1);
        as_bad <= 1;
        cmd(`CMD_AUTO_MEAS, 0);
        await(1, 1, 20);
        await(4, 1, 50);
        rd(`REG_ERROR, 32'(`ERR_AUTOSCALE), 32'hff);
        tacs_i <= 1;
        await(4, 0, 20);
        tacs_i <= 0;
        await(8, 1, 20);
        as_bad <= 0;
        cmd(`CMD_AUTO_MARK, 0);
        await(1, 1, 20);
        await(2, 1, 50);
        await(3, 1, 50);
        await(4, 1, 50);
        tacs_i <= 1;
        await(7, 1, 20);
        await(4, 0, 5);
        await(7, 0, 20);
        tacs_i <= 0;
        tick(6);
        for (int m = 0; m < 6; m++) begin
            cmd(`CMD_MODE, 27'(m));
            tick(3);
            rd(`REG_STATUS, 32'(m) << 8, 32'h700);
        end
        tacs_i <= 1;
        await(6, 1, 50);
        tick(4);
        await(7, 0, 1);
        tacs_i <= 0;
        tick(6);
        rd(`REG_STATUS, 32'h100, 32'h700);
        r = $urandom % 100000000;
        cmd(`CMD_DELAY, 27'(r));
        cmd(`CMD_DELAY, 27'd100000000);
        tick(4);
        chk("delay_o", 32'(r), 32'(delay_o));
        rd(`REG_ERROR, 32'(`ERR_BAD_DELAY), 32'hff);
        key(`KEY_MENU);
        await(5, 1, 10);
        await(10, 0, 1);
        key(`KEY_F1);
        await(0, 0, 10);
        lads_i <= 0;
        tick(4);
        lads_i <= 1;
        await(0, 1, 20);
        key(`KEY_MENU);
        key(`KEY_F2);
        await(5, 0, 10);
        await(0, 1, 1);
        gtl_i <= 1;
        tick(1);
        gtl_i <= 0;
        await(0, 0, 10);
        lads_i <= 0;
        tick(4);
        lads_i <= 1;
        await(0, 1, 20);
        llo_i <= 1;
        tick(4);
        llo_i <= 0;
        await(9, 0, 1);
        key(`KEY_MENU);
        await(5, 0, 1);
        await(9, 1, 1);
        ren_i <= 0;
        await(0, 0, 10);
        tally_and_finish();
    end
endmodule // tb
